// ---- err_record_pkg.sv ----
// Constants, event codes, register map and carrier types of the error record block.
// Assumes one 10 MHz clock, an APB register bus and monitors on the same clock.
package err_record_pkg;
  localparam int STACK_DEPTH = 20;
  localparam int ACTIVE_DEPTH = 8;
  localparam int CLK_PERIOD_NS = 100;
  localparam int TIME_TICK_NS = 1000000;
  localparam int TIME_TICK_CYCLES = TIME_TICK_NS / CLK_PERIOD_NS;
  localparam int NUM_FIX = 16;
  localparam logic [4:0] EXT_SRC = 5'h10;
  typedef enum logic [3:0] {EV_COLD, EV_BROWN, EV_RESTART, EV_CARD, EV_AUTO, EV_QUAD, EV_INDEX,
    EV_RATIO, EV_LOOP1, EV_LOOP2, EV_TERM, EV_NOENC, EV_POSDIR, EV_PROX, EV_SELECT,
    EV_STUCK} event_e;
  localparam logic [15:0] FIX_CODE [NUM_FIX] = '{
    16'h0002, 16'h0003, 16'h0004, 16'h0005, 16'h07D0, 16'h07D1, 16'h07D4, 16'h07D7,
    16'h0FAA, 16'h0FAB, 16'h0FAC, 16'h1388, 16'h138B, 16'h1770, 16'h1B58, 16'h2801};
  localparam logic [15:0] CODE_NOACK_A = 16'h281C;
  localparam logic [15:0] CODE_NOACK_B = 16'h281D;
  localparam logic [15:0] CODE_ACK_LIMIT = 16'h7530;
  localparam logic [15:0] USER_RANGE_LO = 16'h2801;
  localparam logic [15:0] USER_RANGE_HI = 16'h281D;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_STK_SEL = 8'h08;
  localparam logic [7:0] REG_STK_CODE = 8'h0C;
  localparam logic [7:0] REG_STK_TIME = 8'h10;
  localparam logic [7:0] REG_STK_P01 = 8'h14;
  localparam logic [7:0] REG_STK_P23 = 8'h18;
  localparam logic [7:0] REG_ACT_SEL = 8'h1C;
  localparam logic [7:0] REG_ACT_INFO = 8'h20;
  localparam logic [7:0] REG_CMD = 8'h24;
  localparam int CTRL_ACK_EN_BIT = 0;
  localparam int CTRL_ONE_OF_FOUR_BIT = 1;
  localparam int CTRL_ACK_SEL_LSB = 2;
  localparam int CMD_RESTART_BIT = 0;
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam logic [4:0] STK_SEL_RST = 5'h01;
  typedef enum logic [1:0] {BASE_UNIT_CHANNEL_A, BASE_UNIT_CHANNEL_B, EXPANSION_CHANNEL_A,
    EXPANSION_CHANNEL_B} source_e;
  typedef struct packed {
    logic [15:0] code;
    source_e src;
    logic [3:0][15:0] prm;
  } report_s;
  typedef struct packed {
    logic internal;
    logic [31:0] stime;
    report_s rep;
  } entry_s;
  typedef struct packed {
    logic [15:0] code;
    logic internal;
    logic [4:0] src_idx;
  } active_s;
endpackage

// ---- err_record.sv ----
// Error record and acknowledge logic: persistent entry stack, active list, APB slave.
// Assumes monitor condition inputs share mclk; select and start pins are asynchronous.
//
// The register offsets and the APB register port were left to the implementer.
`timescale 1ns/1ps
module err_record
  import err_record_pkg::*;
#(
  parameter int DEPTH = STACK_DEPTH,
  parameter int TICK_CYCLES = TIME_TICK_CYCLES
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic unit_ready,
  input wire logic brown_out,
  input wire logic card_loaded,
  input wire logic restart_menu,
  input wire logic restart_special,
  input wire logic wrong_signal_az,
  input wire logic quad_track_freq_over,
  input wire logic index_freq_over,
  input wire logic quad_to_index_ratio_bad,
  input wire logic feedback_loop_first_open,
  input wire logic feedback_loop_second_open,
  input wire logic terminator_missing,
  input wire logic no_encoder_cfg,
  input wire logic posdir_with_prox,
  input wire logic prox_freq_diff,
  input wire logic prox_valid_signal,
  input wire logic track_a_stuck_high,
  input wire logic [3:0] sel_in,
  input wire logic start_terminal,
  input wire logic rep_valid,
  input report_s rep,
  output logic rep_ready,
  input wire logic ext_recovered,
  output logic fault_led
);
  localparam int IW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam int TW = $clog2(TICK_CYCLES);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);

  // ==========================================================
  // Helper functions
  function automatic logic [IW-1:0] wrap_idx(input logic [IW:0] v);
    wrap_idx = (v >= (IW+1)'(DEPTH)) ? IW'(v - (IW+1)'(DEPTH)) : IW'(v);
  endfunction

  function automatic logic is_user(input logic [15:0] c);
    logic hit;
    hit = (c >= USER_RANGE_LO) && (c <= USER_RANGE_HI);
    for (int i = 0; i < NUM_FIX; i++) begin
      if (c == FIX_CODE[i]) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

  function automatic logic is_info(input logic [15:0] c);
    return (c == FIX_CODE[EV_COLD]) || (c == FIX_CODE[EV_RESTART]) || (c == FIX_CODE[EV_CARD]);
  endfunction

  function automatic logic is_ackable(input logic [15:0] c);
    logic excl;
    excl = is_info(c) || (c == FIX_CODE[EV_AUTO]);
    excl = excl || (c == FIX_CODE[EV_BROWN]) || (c == FIX_CODE[EV_POSDIR]);
    excl = excl || (c == CODE_NOACK_A) || (c == CODE_NOACK_B);
    return !excl && (c < CODE_ACK_LIMIT);
  endfunction

  // ==========================================================
  // Pin synchronisers and edge detection
  logic [3:0] sel_s1_ff, sel_s2_ff, sel_s3_ff;
  logic st_s1_ff, st_s2_ff, st_s3_ff;
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      sel_s1_ff <= 4'h0;
      sel_s2_ff <= 4'h0;
      sel_s3_ff <= 4'h0;
      st_s1_ff <= 1'b0;
      st_s2_ff <= 1'b0;
      st_s3_ff <= 1'b0;
    end else begin
      sel_s1_ff <= sel_in;
      sel_s2_ff <= sel_s1_ff;
      sel_s3_ff <= sel_s2_ff;
      st_s1_ff <= start_terminal;
      st_s2_ff <= st_s1_ff;
      st_s3_ff <= st_s2_ff;
    end
  end

  logic [3:0] ctrl_ff;
  logic cmd_restart_ff;
  wire [1:0] ack_sel = ctrl_ff[CTRL_ACK_SEL_LSB +: 2];
  wire ack_evt = ctrl_ff[CTRL_ACK_EN_BIT] & sel_s2_ff[ack_sel] & ~sel_s3_ff[ack_sel];
  wire start_fall = st_s3_ff & ~st_s2_ff;
  wire restart_clr = restart_menu | restart_special | cmd_restart_ff;
  // The acknowledge also restarts the software, but it does not use the restart clear path,
  // otherwise non-acknowledgeable codes would fall with every acknowledge.
  wire restart_any = restart_clr | ack_evt;
  wire sel_onehot = (sel_s2_ff != 4'h0) && ((sel_s2_ff & 4'(sel_s2_ff - 4'h1)) == 4'h0);

  // ==========================================================
  // System time, counted in ticks of the time divider
  logic [TW-1:0] tick_cnt_ff;
  logic [31:0] stime_ff;
  wire tick = (tick_cnt_ff == TW'(TICK_CYCLES - 1));
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      tick_cnt_ff <= '0;
      stime_ff <= 32'h0;
    end else begin
      tick_cnt_ff <= tick ? '0 : TW'(tick_cnt_ff + 1'b1);
      stime_ff <= tick ? 32'(stime_ff + 32'h1) : stime_ff;
    end
  end

  // ==========================================================
  // Condition levels and event capture
  logic [NUM_FIX-1:0] cond, cond_q_ff, ev_set, pend_ff, nxt_pend, grant_oh;
  logic cold_done_ff;
  always_comb begin
    cond = '0;
    cond[EV_BROWN] = brown_out;
    cond[EV_AUTO] = wrong_signal_az;
    cond[EV_QUAD] = quad_track_freq_over;
    cond[EV_INDEX] = index_freq_over;
    cond[EV_RATIO] = quad_to_index_ratio_bad;
    cond[EV_LOOP1] = feedback_loop_first_open;
    cond[EV_LOOP2] = feedback_loop_second_open;
    cond[EV_TERM] = terminator_missing;
    cond[EV_NOENC] = no_encoder_cfg;
    cond[EV_POSDIR] = posdir_with_prox;
    cond[EV_PROX] = prox_freq_diff;
    cond[EV_SELECT] = ctrl_ff[CTRL_ONE_OF_FOUR_BIT] & ~sel_onehot;
    cond[EV_STUCK] = track_a_stuck_high;
  end
  always_comb begin
    ev_set = cond & ~cond_q_ff;
    ev_set[EV_COLD] = unit_ready & ~cold_done_ff;
    ev_set[EV_RESTART] = restart_any;
    ev_set[EV_CARD] = card_loaded;
  end

  logic [3:0] gidx;
  wire pend_any = |pend_ff;
  always_comb begin
    gidx = 4'h0;
    for (int i = NUM_FIX - 1; i >= 0; i--) begin
      if (pend_ff[i]) begin
        gidx = 4'(i);
      end
    end
  end
  assign grant_oh = pend_any ? (16'h0001 << gidx) : 16'h0000;
  // A new event beats the clear of its own pending bit, so nothing is lost.
  assign nxt_pend = (pend_ff & ~grant_oh) | ev_set;
  assign rep_ready = ~pend_any;
  wire log_wr = pend_any | rep_valid;

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      cond_q_ff <= '0;
      pend_ff <= '0;
      cold_done_ff <= 1'b0;
    end else begin
      cond_q_ff <= cond;
      pend_ff <= nxt_pend;
      cold_done_ff <= cold_done_ff | unit_ready;
    end
  end

  // ==========================================================
  // New entry assembly
  report_s new_rep;
  entry_s new_entry;
  logic [4:0] new_src_idx;
  always_comb begin
    new_rep = rep;
    new_src_idx = EXT_SRC;
    if (pend_any) begin
      new_rep.code = FIX_CODE[gidx];
      new_rep.prm = '0;
      new_rep.src = (gidx == EV_LOOP1 || gidx == EV_LOOP2 || gidx == EV_TERM) ?
        EXPANSION_CHANNEL_A : BASE_UNIT_CHANNEL_A;
      new_src_idx = {1'b0, gidx};
    end
    new_entry.internal = ~is_user(new_rep.code);
    new_entry.stime = stime_ff;
    new_entry.rep = new_rep;
  end

  // ==========================================================
  // Entry stack: a ring of DEPTH entries, oldest first
  logic [IW-1:0] oldest_ff;
  logic [CW-1:0] count_ff;
  logic [4:0] stk_sel_ff;
  entry_s stack_ff [DEPTH];
  wire full = (count_ff == CW'(DEPTH));
  wire [IW-1:0] wr_idx = wrap_idx((IW+1)'(oldest_ff) + (IW+1)'(count_ff));
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      oldest_ff <= '0;
      count_ff <= '0;
    end else if (log_wr && full) begin
      oldest_ff <= wrap_idx((IW+1)'(oldest_ff) + (IW+1)'(1));
    end else if (log_wr) begin
      count_ff <= CW'(count_ff + 1'b1);
    end
  end
  // Storage is not touched by a software restart; only the power-on reset empties the ring.
  for (genvar e = 0; e < DEPTH; e++) begin : g_stack
    always_ff @(posedge mclk) begin
      if (log_wr && wr_idx == IW'(e)) begin
        stack_ff[e] <= new_entry;
      end
    end
  end
  wire stk_sel_ok = (stk_sel_ff != 5'h0) && (CW'(stk_sel_ff) <= count_ff);
  wire [IW-1:0] rd_idx = wrap_idx((IW+1)'(oldest_ff) + (IW+1)'(stk_sel_ff) - (IW+1)'(1));
  wire entry_s rd_entry = stk_sel_ok ? stack_ff[rd_idx] : '0;

  // ==========================================================
  // Active message list
  active_s act_ff [ACTIVE_DEPTH];
  logic [ACTIVE_DEPTH-1:0] act_valid_ff, act_clr, act_gone, act_match;
  logic [2:0] free_idx;
  logic free_any;
  always_comb begin
    free_idx = 3'h0;
    free_any = 1'b0;
    for (int i = ACTIVE_DEPTH - 1; i >= 0; i--) begin
      if (!act_valid_ff[i]) begin
        free_idx = 3'(i);
        free_any = 1'b1;
      end
    end
  end
  // Informational codes go only to the stack; a full list drops further messages.
  wire ins = log_wr & ~is_info(new_rep.code) & ~(|act_match) & free_any;
  for (genvar k = 0; k < ACTIVE_DEPTH; k++) begin : g_act
    wire [15:0] c = act_ff[k].code;
    assign act_gone[k] = (act_ff[k].src_idx == EXT_SRC) ? ext_recovered :
      ~cond[act_ff[k].src_idx[3:0]];
    assign act_match[k] = act_valid_ff[k] & (c == new_rep.code) & ~act_clr[k];
    assign act_clr[k] = act_valid_ff[k] & (
      ((c == FIX_CODE[EV_AUTO]) & act_gone[k]) |
      ((c == FIX_CODE[EV_PROX]) & (prox_valid_signal | start_fall | ack_evt)) |
      (ack_evt & is_ackable(c) & ~act_ff[k].internal & act_gone[k]) |
      (restart_clr & ~act_ff[k].internal & act_gone[k]));
    always_ff @(posedge mclk) begin
      if (!rstn) begin
        act_valid_ff[k] <= 1'b0;
        act_ff[k] <= '0;
      end else if (ins && free_idx == 3'(k)) begin
        act_valid_ff[k] <= 1'b1;
        act_ff[k] <= '{code: new_rep.code, internal: new_entry.internal, src_idx: new_src_idx};
      end else if (act_clr[k]) begin
        act_valid_ff[k] <= 1'b0;
      end
    end

    property p_info_never;
      act_valid_ff[k] |-> !is_info(act_ff[k].code);
    endproperty
    a_info_never: assert property (p_info_never) else $error("info code active");
    property p_high_keep;
      act_valid_ff[k] && act_ff[k].code >= CODE_ACK_LIMIT |=> act_valid_ff[k];
    endproperty
    a_high_keep: assert property (p_high_keep) else $error("high code cleared");
    property p_auto_clear;
      act_valid_ff[k] && act_ff[k].code == FIX_CODE[EV_AUTO] && act_gone[k] |=>
        !act_valid_ff[k];
    endproperty
    a_auto_clear: assert property (p_auto_clear) else $error("2000 not auto cleared");
    property p_hold;
      act_valid_ff[k] && !act_gone[k] && act_ff[k].code != FIX_CODE[EV_PROX] |=>
        act_valid_ff[k];
    endproperty
    a_hold: assert property (p_hold) else $error("message left with cause present");
    property p_ack_clear;
      act_valid_ff[k] && ack_evt && act_gone[k] && !act_ff[k].internal &&
        is_ackable(act_ff[k].code) |=> !act_valid_ff[k];
    endproperty
    a_ack_clear: assert property (p_ack_clear) else $error("ack did not clear");
    property p_prox_start;
      act_valid_ff[k] && act_ff[k].code == FIX_CODE[EV_PROX] && start_fall |=>
        !act_valid_ff[k];
    endproperty
    a_prox_start: assert property (p_prox_start) else $error("6000 kept after start");
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      fault_led <= 1'b0;
    end else begin
      fault_led <= |act_valid_ff;
    end
  end

  // ==========================================================
  // APB slave: zero wait states, read data captured in the setup cycle
  logic [2:0] act_sel_ff;
  wire a_ctrl = (paddr == REG_CTRL);
  wire a_status = (paddr == REG_STATUS);
  wire a_stk_sel = (paddr == REG_STK_SEL);
  wire a_stk_code = (paddr == REG_STK_CODE);
  wire a_stk_time = (paddr == REG_STK_TIME);
  wire a_stk_p01 = (paddr == REG_STK_P01);
  wire a_stk_p23 = (paddr == REG_STK_P23);
  wire a_act_sel = (paddr == REG_ACT_SEL);
  wire a_act_info = (paddr == REG_ACT_INFO);
  wire a_cmd = (paddr == REG_CMD);
  wire mapped = a_ctrl | a_status | a_stk_sel | a_stk_code | a_stk_time | a_stk_p01 |
    a_stk_p23 | a_act_sel | a_act_info | a_cmd;
  wire wr_en = psel & penable & pwrite & mapped;
  wire rd_setup = psel & ~penable & ~pwrite;
  wire [31:0] rd_status = {15'h0, fault_led, act_valid_ff, 3'h0, 5'(count_ff)};
  wire [31:0] rd_code = {3'h0, stk_sel_ff, 5'h0, rd_entry.rep.src, rd_entry.internal,
    rd_entry.rep.code};
  wire [31:0] rd_act = {13'h0, ~act_gone[act_sel_ff], act_ff[act_sel_ff].internal,
    act_valid_ff[act_sel_ff], act_ff[act_sel_ff].code};
  wire [31:0] rd_data =
    a_ctrl ? {28'h0, ctrl_ff} :
    a_status ? rd_status :
    a_stk_sel ? {27'h0, stk_sel_ff} :
    a_stk_code ? rd_code :
    a_stk_time ? rd_entry.stime :
    a_stk_p01 ? {rd_entry.rep.prm[1], rd_entry.rep.prm[0]} :
    a_stk_p23 ? {rd_entry.rep.prm[3], rd_entry.rep.prm[2]} :
    a_act_sel ? {29'h0, act_sel_ff} :
    a_act_info ? rd_act : 32'h0;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      prdata <= 32'h0;
      ctrl_ff <= CTRL_RST;
      stk_sel_ff <= STK_SEL_RST;
      act_sel_ff <= 3'h0;
      cmd_restart_ff <= 1'b0;
    end else begin
      prdata <= rd_setup ? rd_data : prdata;
      ctrl_ff <= (wr_en && a_ctrl) ? pwdata[3:0] : ctrl_ff;
      stk_sel_ff <= (wr_en && a_stk_sel) ? pwdata[4:0] : stk_sel_ff;
      act_sel_ff <= (wr_en && a_act_sel) ? pwdata[2:0] : act_sel_ff;
      cmd_restart_ff <= wr_en & a_cmd & pwdata[CMD_RESTART_BIT];
    end
  end

  // ==========================================================
  // Checks on the stack, the event capture, the active list and the fault indicator

  property p_count_cap;
    count_ff <= CW'(DEPTH);
  endproperty
  a_count_cap: assert property (p_count_cap) else $error("stack count too high");
  property p_count_grow;
    log_wr && !full |=> count_ff == CW'($past(count_ff) + 1'b1);
  endproperty
  a_count_grow: assert property (p_count_grow) else $error("stack did not grow");
  property p_drop_oldest;
    log_wr && full |=> full && oldest_ff == wrap_idx((IW+1)'($past(oldest_ff)) + (IW+1)'(1));
  endproperty
  a_drop_oldest: assert property (p_drop_oldest) else $error("oldest not dropped");
  property p_entry_code;
    log_wr |=> stack_ff[$past(wr_idx)].rep.code == $past(new_rep.code);
  endproperty
  a_entry_code: assert property (p_entry_code) else $error("entry code not stored");
  property p_cold;
    unit_ready && !cold_done_ff |=> pend_ff[EV_COLD] ##[0:16] (gidx == EV_COLD && pend_any);
  endproperty
  a_cold: assert property (p_cold) else $error("cold start not logged");
  property p_restart;
    restart_any |=> pend_ff[EV_RESTART];
  endproperty
  a_restart: assert property (p_restart) else $error("restart not logged");
  property p_select;
    $rose(cond[EV_SELECT]) |=> ##[0:16] (pend_any && gidx == EV_SELECT);
  endproperty
  a_select: assert property (p_select) else $error("select fault not logged");
  property p_fault;
    act_valid_ff != '0 |=> fault_led;
  endproperty
  a_fault: assert property (p_fault) else $error("fault indicator dark");
  property p_insert;
    ins |=> act_valid_ff[$past(free_idx)] && act_ff[$past(free_idx)].code == $past(new_rep.code);
  endproperty
  a_insert: assert property (p_insert) else $error("active message not stored");
endmodule

// ---- sel_panel.sv ----
// Operator side model: select inputs and start terminal seen by the error record.
// Assumes its tasks are called right after a rising edge of mclk.
`timescale 1ns/1ps
module sel_panel (
  input wire logic mclk,
  output logic [3:0] sel_in,
  output logic start_terminal
);
  // ==========
  // Pin drive
  // Each level is held six cycles so the two-stage synchronisers cannot miss it.
  initial begin
    sel_in = 4'h0;
    start_terminal = 1'b0;
  end
  task automatic press_ack(input int idx);
    sel_in <= sel_in | 4'(1 << idx);
    repeat (6) @(posedge mclk);
    sel_in <= sel_in & ~4'(1 << idx);
    repeat (6) @(posedge mclk);
  endtask
  task automatic pulse_start();
    start_terminal <= 1'b1;
    repeat (6) @(posedge mclk);
    start_terminal <= 1'b0;
    repeat (6) @(posedge mclk);
  endtask
endmodule

// ---- err_record_tb.sv ----
// Self-checking bench: APB reads note their expectation, a monitor compares them.
// Assumes err_record_pkg, err_record and sel_panel are compiled first.
`timescale 1ns/1ps
module err_record_tb;
  import err_record_pkg::*;
  // ==========
  // Signals and design
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, rep_ready, fault_led;
  logic unit_ready = 1'b0, brown_out = 1'b0, card_loaded = 1'b0;
  logic restart_menu = 1'b0, ext_recovered = 1'b0, rep_valid = 1'b0;
  logic [10:0] lvl = 11'h000;
  logic [3:0] sel_in;
  logic start_terminal;
  report_s rep = '0;
  report_s sent;
  logic [15:0] seed = 16'h002E;
  logic [31:0] eq[$], mq[$];
  logic erq[$];
  logic [15:0] log_q[$];
  int mismatches = 0, n_checks = 0;
  localparam int TB_TICK = 4;
  logic restart_special = 1'b0, prox_valid = 1'b0;
  int edge_n = 0, rep_edge = 0;
  always #50 mclk = ~mclk;
  // Edges since reset release; the system time advances once per TB_TICK of them.
  always @(posedge mclk) begin
    if (rstn) edge_n <= edge_n + 1;
  end
  err_record #(.DEPTH(STACK_DEPTH), .TICK_CYCLES(TB_TICK)) u_err_record (
    .mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .unit_ready(unit_ready), .brown_out(brown_out), .card_loaded(card_loaded),
    .restart_menu(restart_menu), .restart_special(restart_special), .wrong_signal_az(lvl[10]),
    .quad_track_freq_over(lvl[0]), .index_freq_over(lvl[1]),
    .quad_to_index_ratio_bad(lvl[2]), .feedback_loop_first_open(lvl[3]),
    .feedback_loop_second_open(lvl[4]), .terminator_missing(lvl[5]),
    .no_encoder_cfg(lvl[6]), .posdir_with_prox(lvl[7]), .prox_freq_diff(lvl[8]),
    .prox_valid_signal(prox_valid), .track_a_stuck_high(lvl[9]), .sel_in(sel_in),
    .start_terminal(start_terminal), .rep_valid(rep_valid), .rep(rep),
    .rep_ready(rep_ready), .ext_recovered(ext_recovered), .fault_led(fault_led));
  sel_panel u_sel_panel (.mclk(mclk), .sel_in(sel_in), .start_terminal(start_terminal));
  // ==========
  // Checking
  task automatic fail(input string m);
    mismatches++;
    $display("wrong value at %0t: %s", $time, m);
  endtask
  task automatic chk(input logic got, input logic exp, input string m);
    n_checks++;
    if (got !== exp) fail(m);
  endtask
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  always @(posedge mclk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
      n_checks++;
      if (eq.size() == 0) fail("read without expectation");
      else begin
        if ((prdata & mq[0]) !== eq[0] || pslverr !== erq[0]) fail("read data");
        void'(eq.pop_front());
        void'(mq.pop_front());
        void'(erq.pop_front());
      end
    end
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // ==========
  // Drivers
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) fail("no pready");
    psel <= 1'b0;
    penable <= 1'b0;
    // One idle edge keeps two calls from writing psel in the same time step.
    @(posedge mclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
                    input logic er);
    eq.push_back(e & m);
    mq.push_back(m);
    erq.push_back(er);
    apb(1'b0, a, 32'h0);
  endtask
  // Status word: fault indicator, active slot bits, stored entry count.
  task automatic st(input logic f, input logic [7:0] act, input logic [4:0] cnt);
    rd(REG_STATUS, {15'h0, f, act, 3'h0, cnt}, 32'h0001_FF1F, 1'b0);
  endtask
  task automatic logc(input logic [15:0] c);
    log_q.push_back(c);
    if (log_q.size() > STACK_DEPTH) void'(log_q.pop_front());
  endtask
  task automatic send_rep(input logic [15:0] c);
    report_s r;
    int n;
    r.code = c;
    r.src = EXPANSION_CHANNEL_B;
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      r.prm[i] = seed;
    end
    sent = r;
    rep <= r;
    rep_valid <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (rep_ready !== 1'b1 && n < 50);
    if (n >= 50) fail("no rep_ready");
    rep_edge = edge_n;
    rep_valid <= 1'b0;
  endtask
  // ==========
  // Scenarios
  initial begin
    cyc(4);
    rstn <= 1'b1;
    @(posedge mclk);
    rd(REG_CTRL, 32'h0, 32'hFFFF_FFFF, 1'b0);
    rd(REG_STK_SEL, 32'h1, 32'hFFFF_FFFF, 1'b0);
    rd(8'h28, 32'h0, 32'hFFFF_FFFF, 1'b1);
    st(1'b0, 8'h00, 5'd0);
    unit_ready <= 1'b1;
    cyc(6);
    logc(16'h0002);
    rd(REG_STK_CODE, 32'h0100_0002, 32'h1F07_FFFF, 1'b0);
    st(1'b0, 8'h00, 5'd1);
    lvl[0] <= 1'b1;
    cyc(6);
    logc(16'h07D1);
    apb(1'b1, REG_ACT_SEL, 32'h0);
    rd(REG_ACT_INFO, 32'h0005_07D1, 32'h0007_FFFF, 1'b0);
    st(1'b1, 8'h01, 5'd2);
    lvl[7] <= 1'b1;
    cyc(6);
    logc(16'h138B);
    apb(1'b1, REG_CTRL, 32'h1);
    lvl[0] <= 1'b0;
    lvl[7] <= 1'b0;
    u_sel_panel.press_ack(0);
    logc(16'h0004);
    st(1'b1, 8'h02, 5'd4);
    apb(1'b1, REG_CMD, 32'h1);
    cyc(4);
    logc(16'h0004);
    st(1'b0, 8'h00, 5'd5);
    lvl[10] <= 1'b1;
    cyc(6);
    logc(16'h07D0);
    lvl[10] <= 1'b0;
    cyc(4);
    st(1'b0, 8'h00, 5'd6);
    lvl[8] <= 1'b1;
    cyc(6);
    logc(16'h1770);
    lvl[8] <= 1'b0;
    u_sel_panel.pulse_start();
    st(1'b0, 8'h00, 5'd7);
    send_rep(CODE_ACK_LIMIT);
    cyc(6);
    logc(CODE_ACK_LIMIT);
    ext_recovered <= 1'b1;
    u_sel_panel.press_ack(0);
    logc(16'h0004);
    st(1'b1, 8'h01, 5'd9);
    brown_out <= 1'b1;
    card_loaded <= 1'b1;
    @(posedge mclk);
    card_loaded <= 1'b0;
    cyc(6);
    logc(16'h0003);
    logc(16'h0005);
    lvl[9:0] <= 10'h3FF;
    cyc(20);
    for (int i = 5; i < 14; i++) logc(FIX_CODE[i]);
    logc(FIX_CODE[15]);
    apb(1'b1, REG_CTRL, 32'h3);
    cyc(10);
    logc(FIX_CODE[14]);
    st(1'b1, 8'hFF, 5'd20);
    for (int p = 1; p <= STACK_DEPTH; p++) begin
      apb(1'b1, REG_STK_SEL, p);
      rd(REG_STK_CODE, {3'h0, p[4:0], 8'h00, log_q[p-1]}, 32'h1F00_FFFF, 1'b0);
    end
    apb(1'b1, REG_STK_SEL, 32'h6);
    rd(REG_STK_CODE, 32'h0607_7530, 32'h1F07_FFFF, 1'b0);
    rd(REG_STK_P01, {sent.prm[1], sent.prm[0]}, 32'hFFFF_FFFF, 1'b0);
    rd(REG_STK_P23, {sent.prm[3], sent.prm[2]}, 32'hFFFF_FFFF, 1'b0);
    rd(REG_STK_TIME, 32'(rep_edge / TB_TICK), 32'hFFFF_FFFF, 1'b0);
    lvl <= 11'h000;
    brown_out <= 1'b0;
    restart_menu <= 1'b1;
    @(posedge mclk);
    restart_menu <= 1'b0;
    cyc(4);
    st(1'b1, 8'h01, 5'd20);
    lvl[8] <= 1'b1;
    cyc(6);
    st(1'b1, 8'h03, 5'd20);
    prox_valid <= 1'b1;
    cyc(4);
    st(1'b1, 8'h01, 5'd20);
    restart_special <= 1'b1;
    @(posedge mclk);
    restart_special <= 1'b0;
    cyc(4);
    apb(1'b1, REG_STK_SEL, 32'h13);
    rd(REG_STK_CODE, 32'h1300_1770, 32'h1F07_FFFF, 1'b0);
    apb(1'b1, REG_STK_SEL, 32'h14);
    rd(REG_STK_CODE, 32'h1400_0004, 32'h1F07_FFFF, 1'b0);
    chk(fault_led, 1'b1, "fault indicator");
    cyc(2);
    if (eq.size() != 0) fail("reads left unchecked");
    test_done();
  end
  initial begin
    repeat (3000) @(posedge mclk);
    mismatches++;
    test_done();
  end
endmodule
